/* rtl/nbu_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.vh"

// ==========================================================
// nine-bit multiprocessor serial port
module nbu_top (
  // clock and reset
  input wire mclk,
  input wire srst,
  // special-function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output wire [7:0] sfr_rdata,
  // bit-addressed write port
  input wire sfr_bit_wr,
  input wire [7:0] sfr_bit_addr,
  input wire sfr_bit_val,
  // baud timer inputs
  input wire t1_ovf,
  input wire t1_tick,
  input wire [7:0] t1_reload,
  // interrupt
  input wire irq_enable,
  output wire irq,
  // transmit queue space
  output wire tx_ready,
  // serial lines
  input wire rxd,
  output wire txd
);
  // ==========================================================
  // state encodings
  localparam TX_IDLE = 5'b00001; // line idle
  localparam TX_START = 5'b00010; // start bit out
  localparam TX_DATA = 5'b00100; // data bits out
  localparam TX_NINTH = 5'b01000; // ninth bit out
  localparam TX_STOP = 5'b10000; // stop bit out
  localparam RX_IDLE = 5'b00001; // waiting for start edge
  localparam RX_START = 5'b00010; // checking start bit
  localparam RX_DATA = 5'b00100; // sampling data bits
  localparam RX_NINTH = 5'b01000; // sampling ninth bit
  localparam RX_STOP = 5'b10000; // sampling stop bit
  localparam [7:0] ADDR_CONTROL = `NBU_ADDR_CONTROL; // control address for bit decode

  // ==========================================================
  // control register fields
  reg mode_q; // nine_bit_select
  reg filter_q; // multiproc_filter_enable
  reg ren_q; // receive_enable_field
  reg tx_ninth_bit_q; // tx_ninth_bit
  reg rx_ninth_bit_q; // rx_ninth_bit
  reg tx_done_flag_q; // tx_done_flag
  reg rx_done_flag_q; // rx_done_flag
  reg [7:0] rx_buf_q; // received byte buffer
  reg [7:0] rdata_q; // read data register
  reg irq_q; // interrupt request
  wire [7:0] control_view; // assembled control byte

  // ==========================================================
  // transmitter state
  reg [4:0] tx_state_q; // transmit state
  reg [7:0] tx_shift_q; // outgoing byte
  reg [3:0] tx_cnt_q; // data bits sent
  reg tx_ninth_q; // latched ninth bit
  reg tx_half_q; // overflow divide-by-two
  reg txd_q; // line driver
  reg tx_set; // tx done set request
  wire tx_tick; // one bit time
  wire fifo_valid; // queued byte present
  wire [7:0] fifo_data; // queued byte
  reg fifo_pop; // take queued byte
  wire fifo_in_ready; // queue has space
  wire data_wr; // data buffer written

  // ==========================================================
  // receiver state
  reg [4:0] rx_state_q; // receive state
  reg [7:0] rx_shift_q; // incoming byte
  reg [3:0] rx_cnt_q; // data bits taken
  reg rx_ninth_q; // sampled ninth bit
  reg rx_skip_q; // skip alternate overflows
  reg rxd_q; // registered line level
  reg rxd_prev_q; // previous line level
  reg rx_commit; // store frame this cycle
  reg rx_commit_ninth; // value for rx ninth field
  reg rx_start_seen; // start edge accepted
  wire rx_ovf; // receive timer overflow
  wire rx_sample; // sampling point

  // ==========================================================
  // software write masks for the control register
  reg [7:0] wmask; // bits written this cycle
  reg [7:0] wval; // values written

  assign sfr_rdata = rdata_q;
  assign irq = irq_q;
  assign txd = txd_q;
  assign tx_ready = fifo_in_ready;

  // bit 6 always reads one
  assign control_view = {mode_q, 1'b1, filter_q, ren_q, tx_ninth_bit_q,
                         rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
  assign data_wr = sfr_wr & (sfr_addr == `NBU_ADDR_DATA);

  // ==========================================================
  // byte and bit writes to the control register
  always @*
  begin
    wmask = 8'h00;
    wval = 8'h00;
    if (sfr_wr && (sfr_addr == `NBU_ADDR_CONTROL))
    begin
      // whole byte written
      wmask = 8'hff;
      wval = sfr_wdata;
    end
    else if (sfr_bit_wr && (sfr_bit_addr[7:3] == ADDR_CONTROL[7:3]))
    begin
      // single bit written
      wmask[sfr_bit_addr[2:0]] = 1'b1;
      wval[sfr_bit_addr[2:0]] = sfr_bit_val;
    end
  end

  // ==========================================================
  // transmit queue fed by data buffer writes
  nbu_fifo #(
    .WIDTH(`NBU_FIFO_WIDTH),
    .DEPTH(`NBU_FIFO_DEPTH),
    .AW(`NBU_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(data_wr),
    .in_data(sfr_wdata),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // ==========================================================
  // receive timer copy, restarted by the start edge
  nbu_baud u_rx_timer (
    .mclk(mclk),
    .srst(srst),
    .tick_en(t1_tick),
    .reload_val(t1_reload),
    .force_reload(rx_start_seen),
    .ovf(rx_ovf)
  );

  // bit time is every second overflow
  assign tx_tick = t1_ovf & tx_half_q;
  assign rx_sample = rx_ovf & ~rx_skip_q;

  // ==========================================================
  // transmit sequencer
  always @(posedge mclk)
  begin
    if (srst)
    begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_cnt_q <= 4'h0;
      tx_ninth_q <= 1'b0;
      tx_half_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else
    begin
      if (t1_ovf)
        tx_half_q <= ~tx_half_q;
      if (tx_tick)
      begin
        case (tx_state_q)
          TX_IDLE:
          begin
            // launch next queued byte
            if (fifo_valid)
            begin
              tx_state_q <= TX_START;
              tx_shift_q <= fifo_data;
              tx_ninth_q <= tx_ninth_bit_q;
              txd_q <= 1'b0;
            end
          end
          TX_START:
          begin
            // first data bit, lsb first
            tx_state_q <= TX_DATA;
            txd_q <= tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_cnt_q <= 4'h1;
          end
          TX_DATA:
          begin
            if (tx_cnt_q == `NBU_DATA_BITS)
            begin
              if (mode_q)
              begin
                // ninth bit follows the byte
                tx_state_q <= TX_NINTH;
                txd_q <= tx_ninth_q;
              end
              else
              begin
                tx_state_q <= TX_STOP;
                txd_q <= 1'b1;
              end
            end
            else
            begin
              txd_q <= tx_shift_q[0];
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              tx_cnt_q <= tx_cnt_q + 4'h1;
            end
          end
          TX_NINTH:
          begin
            tx_state_q <= TX_STOP;
            txd_q <= 1'b1;
          end
          TX_STOP:
          begin
            // back to back frames if queued
            if (fifo_valid)
            begin
              tx_state_q <= TX_START;
              tx_shift_q <= fifo_data;
              tx_ninth_q <= tx_ninth_bit_q;
              txd_q <= 1'b0;
            end
            else
              tx_state_q <= TX_IDLE;
          end
          default:
          begin
            tx_state_q <= TX_IDLE;
            txd_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // queue pop and done pulse on frame edges
  always @*
  begin
    fifo_pop = 1'b0;
    tx_set = 1'b0;
    if (tx_tick && fifo_valid && (tx_state_q == TX_IDLE || tx_state_q == TX_STOP))
      fifo_pop = 1'b1;
    if (tx_tick && ((tx_state_q == TX_NINTH) ||
        (tx_state_q == TX_DATA && tx_cnt_q == `NBU_DATA_BITS && !mode_q)))
      tx_set = 1'b1;
  end

  // ==========================================================
  // receive sequencer
  always @(posedge mclk)
  begin
    if (srst)
    begin
      rx_state_q <= RX_IDLE;
      rx_shift_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      rx_ninth_q <= 1'b0;
      rx_skip_q <= 1'b0;
      rxd_q <= 1'b1;
      rxd_prev_q <= 1'b1;
    end
    else
    begin
      rxd_q <= rxd;
      rxd_prev_q <= rxd_q;
      if (rx_ovf && rx_state_q != RX_START)
        rx_skip_q <= ~rx_skip_q;
      case (rx_state_q)
        RX_IDLE:
        begin
          // falling edge opens a frame
          if (rx_start_seen)
            rx_state_q <= RX_START;
        end
        RX_START:
        begin
          // half bit in: confirm start level
          if (rx_ovf)
          begin
            rx_skip_q <= 1'b1;
            rx_cnt_q <= 4'h0;
            if (rxd_q)
              rx_state_q <= RX_IDLE;
            else
              rx_state_q <= RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_sample)
          begin
            // shift in lsb first
            rx_shift_q <= {rxd_q, rx_shift_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == `NBU_DATA_BITS - 4'h1)
              rx_state_q <= mode_q ? RX_NINTH : RX_STOP;
          end
        end
        RX_NINTH:
        begin
          if (rx_sample)
          begin
            rx_ninth_q <= rxd_q;
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (rx_sample)
            rx_state_q <= RX_IDLE;
        end
        default:
          rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // start detection and commit decision
  always @*
  begin
    rx_start_seen = (rx_state_q == RX_IDLE) && ren_q && rxd_prev_q && !rxd_q;
    rx_commit = 1'b0;
    rx_commit_ninth = 1'b0;
    if (rx_state_q == RX_STOP && rx_sample)
    begin
      if (mode_q)
      begin
        // ninth bit kept, stop level ignored
        rx_commit_ninth = rx_ninth_q;
        rx_commit = !rx_done_flag_q && (!filter_q || rx_ninth_q);
      end
      else
      begin
        // stop level goes to the ninth field
        rx_commit_ninth = rxd_q;
        rx_commit = !rx_done_flag_q && (!filter_q || rxd_q);
      end
    end
  end

  // ==========================================================
  // control fields, buffers, read data and interrupt
  always @(posedge mclk)
  begin
    if (srst)
    begin
      mode_q <= 1'b0;
      filter_q <= 1'b0;
      ren_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
      rx_ninth_bit_q <= 1'b0;
      tx_done_flag_q <= 1'b0;
      rx_done_flag_q <= 1'b0;
      rx_buf_q <= `NBU_RST_DATA;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      // plain software fields
      if (wmask[`NBU_POS_MODE])
        mode_q <= wval[`NBU_POS_MODE];
      if (wmask[`NBU_POS_FILTER])
        filter_q <= wval[`NBU_POS_FILTER];
      if (wmask[`NBU_POS_RX_ENABLE])
        ren_q <= wval[`NBU_POS_RX_ENABLE];
      if (wmask[`NBU_POS_TX_NINTH])
        tx_ninth_bit_q <= wval[`NBU_POS_TX_NINTH];
      // hardware load wins over software write
      if (rx_commit)
      begin
        rx_ninth_bit_q <= rx_commit_ninth;
        rx_buf_q <= rx_shift_q;
      end
      else if (wmask[`NBU_POS_RX_NINTH])
        rx_ninth_bit_q <= wval[`NBU_POS_RX_NINTH];
      // done flags: set wins, only software clears
      if (tx_set)
        tx_done_flag_q <= 1'b1;
      else if (wmask[`NBU_POS_TX_DONE])
        tx_done_flag_q <= wval[`NBU_POS_TX_DONE];
      if (rx_commit)
        rx_done_flag_q <= 1'b1;
      else if (wmask[`NBU_POS_RX_DONE])
        rx_done_flag_q <= wval[`NBU_POS_RX_DONE];
      // read data registered
      if (sfr_rd)
      begin
        if (sfr_addr == `NBU_ADDR_CONTROL)
          rdata_q <= control_view;
        else if (sfr_addr == `NBU_ADDR_DATA)
          rdata_q <= rx_buf_q;
        else
          rdata_q <= 8'h00;
      end
      // request follows flags while enabled
      irq_q <= irq_enable & (tx_done_flag_q | rx_done_flag_q);
    end
  end
endmodule // nbu_top

`default_nettype wire

/* inc/nbu_consts.vh */
`ifndef NBU_CONSTS_VH
`define NBU_CONSTS_VH

// ==========================================================
// special-function addresses
`define NBU_ADDR_CONTROL 8'h98
`define NBU_ADDR_DATA 8'h99

// ==========================================================
// control register field positions
`define NBU_BIT_RX_DONE 1
`define NBU_BIT_TX_DONE 1
`define NBU_POS_RX_DONE 0
`define NBU_POS_TX_DONE 1
`define NBU_POS_RX_NINTH 2
`define NBU_POS_TX_NINTH 3
`define NBU_POS_RX_ENABLE 4
`define NBU_POS_FILTER 5
`define NBU_POS_UNUSED 6
`define NBU_POS_MODE 7

// ==========================================================
// reset values
`define NBU_RST_CONTROL 8'h40
`define NBU_RST_DATA 8'h00
`define NBU_RST_TIMER 8'h00

// ==========================================================
// framing counts
`define NBU_DATA_BITS 4'h8
`define NBU_TIMER_TOP 8'hff

// ==========================================================
// transmit buffer shape
`define NBU_FIFO_WIDTH 8
`define NBU_FIFO_DEPTH 32
`define NBU_FIFO_AW 5

`endif

/* rtl/nbu_fifo.v */
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.vh"

// ==========================================================
// transmit byte queue with registered output word
module nbu_fifo #(
  parameter WIDTH = `NBU_FIFO_WIDTH,
  parameter DEPTH = `NBU_FIFO_DEPTH,
  parameter AW = `NBU_FIFO_AW
) (
  // clock and reset
  input wire mclk,
  input wire srst,
  // filling side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // draining side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage array
  reg [AW-1:0] wptr_q; // write pointer
  reg [AW-1:0] rptr_q; // read pointer
  reg [AW:0] cnt_q; // words held in the array
  reg ready_q; // array has space
  reg out_valid_q; // output stage holds a word
  reg [WIDTH-1:0] out_data_q; // output stage word
  wire push; // word accepted
  wire pop; // word moved to output stage
  reg [AW:0] cnt_d; // next count

  assign in_ready = ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
  assign push = in_valid & ready_q;
  assign pop = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  // count follows push and pop
  always @*
  begin
    cnt_d = cnt_q;
    if (push & ~pop)
      cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
  end

  // array writes, no reset needed on data
  always @(posedge mclk)
  begin
    if (push)
      mem_q[wptr_q] <= in_data;
  end

  // pointers, flags and output register
  always @(posedge mclk)
  begin
    if (srst)
    begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      ready_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end
    else
    begin
      cnt_q <= cnt_d;
      // space flag kept in a register so the port comes from a flip-flop
      ready_q <= (cnt_d != DEPTH[AW:0]);
      if (push)
        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
      begin
        // refill output stage from array
        out_data_q <= mem_q[rptr_q];
        out_valid_q <= 1'b1;
        rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      else if (out_ready)
        out_valid_q <= 1'b0;
    end
  end
endmodule // nbu_fifo

`default_nettype wire

/* rtl/nbu_baud.v */
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.vh"

// ==========================================================
// receive timer: copy of the 8-bit auto-reload timer
module nbu_baud (
  // clock and reset
  input wire mclk,
  input wire srst,
  // timer clocking
  input wire tick_en,
  input wire [7:0] reload_val,
  input wire force_reload,
  // overflow pulse
  output wire ovf
);
  reg [7:0] cnt_q; // timer count
  reg ovf_q; // overflow pulse

  assign ovf = ovf_q;

  // count up, reload at top or on forced restart
  always @(posedge mclk)
  begin
    if (srst)
    begin
      cnt_q <= `NBU_RST_TIMER;
      ovf_q <= 1'b0;
    end
    else
    begin
      ovf_q <= 1'b0;
      if (force_reload)
        cnt_q <= reload_val;
      else if (tick_en)
      begin
        if (cnt_q == `NBU_TIMER_TOP)
        begin
          cnt_q <= reload_val;
          ovf_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // nbu_baud

`default_nettype wire

/* testbench/nbu_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.vh"

// ==========================================================
// port-level checks of the serial port
module nbu_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_rdata,
  // timer, interrupt, queue and line
  input wire logic t1_ovf,
  input wire logic irq_enable,
  input wire logic irq,
  input wire logic tx_ready,
  input wire logic txd
);
  wire logic data_wr; // byte write to the data address
  wire logic sw_wr; // any software write
  assign data_wr = sfr_wr && (sfr_addr == `NBU_ADDR_DATA);
  assign sw_wr = sfr_wr || sfr_bit_wr;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // ==========================================================
  // assertions
  reset_values_a: assert property ($fell(srst) |-> txd && !irq && tx_ready)
    else $error("line, irq or queue state wrong after reset");
  irq_gate_a: assert property (!irq_enable |=> !irq)
    else $error("irq high while disabled");
  irq_flag_a: assert property (irq && sfr_rd && sfr_addr == `NBU_ADDR_CONTROL && !$past(sw_wr)
    |=> sfr_rdata[1] || sfr_rdata[0]) else $error("irq without a done flag");
  irq_fall_a: assert property ($fell(irq) |-> !$past(irq_enable) || $past(sw_wr, 2) || $past(srst))
    else $error("irq dropped without software clear");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  unmapped_a: assert property (sfr_rd && sfr_addr != `NBU_ADDR_CONTROL && sfr_addr != `NBU_ADDR_DATA
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  unused_bit_a: assert property (sfr_rd && sfr_addr == `NBU_ADDR_CONTROL |=> sfr_rdata[6])
    else $error("control bit 6 read low");
  tick_only_a: assert property ($changed(txd) |-> $past(t1_ovf) || $past(srst))
    else $error("serial out moved off a timer tick");
  queue_full_a: assert property ($fell(tx_ready) |-> $past(data_wr) || $past(data_wr, 2))
    else $error("queue filled without a data write");
endmodule // nbu_checker

`default_nettype wire

/* testbench/nbu_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// remote node: drives the receive line, listens on transmit
module nbu_remote_node #(
  parameter BIT_CYC = 16
) (
  // clock
  input wire logic mclk,
  // serial lines seen from the far end
  input wire logic txd,
  output var logic rxd
);
  logic [10:0] got_q; // last frame heard, start bit at 0
  int got_cnt; // frames heard

  // one frame: start low, data lsb first, ninth if nine-bit, stop
  task automatic send(input logic [7:0] d, input logic nine, input logic ninth, input logic stop);
    logic [10:0] bits;
    bits = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    @(negedge mclk);
    for (int i = 0; i < (nine ? 11 : 10); i++)
    begin
      rxd = bits[i];
      repeat (BIT_CYC) @(negedge mclk);
    end
    rxd = 1'b1; // line idles high
    repeat (BIT_CYC) @(negedge mclk);
  endtask

  // listener: mid-bit samples of an eleven-bit frame
  initial
  begin
    rxd = 1'b1;
    got_cnt = 0;
    forever
    begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(negedge mclk);
      for (int i = 0; i < 11; i++)
      begin
        got_q[i] = txd;
        if (i < 10)
          repeat (BIT_CYC) @(negedge mclk);
      end
      got_cnt++;
    end
  end
endmodule // nbu_remote_node

`default_nettype wire

/* testbench/tb_nine_bit_uart_multiproc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nbu_consts.vh"

// ==========================================================
// self-checking bench for the serial port
module tb_nine_bit_uart_multiproc;
  localparam logic [7:0] CTL = `NBU_ADDR_CONTROL;
  localparam logic [7:0] DAT = `NBU_ADDR_DATA;
  logic mclk, srst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, t1_tick, irq_enable;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, t1_reload, rd_q;
  logic [2:0] div_q = 3'h0; // overflow divider
  logic t1_ovf = 1'b0; // timer overflow pulse
  logic ovf_hold = 1'b0; // stalls the transmit bit rate
  wire logic [7:0] sfr_rdata;
  wire logic irq, tx_ready, rxd, txd;
  int mismatches, checks;

  nbu_top nbu_top_inst (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_val(sfr_bit_val), .t1_ovf(t1_ovf), .t1_tick(t1_tick), .t1_reload(t1_reload),
    .irq_enable(irq_enable), .irq(irq), .tx_ready(tx_ready), .rxd(rxd), .txd(txd));
  nbu_remote_node nbu_remote_node_inst (.mclk(mclk), .txd(txd), .rxd(rxd));

  // ==========================================================
  // clock and timer overflow every eight cycles
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk)
  begin
    div_q <= div_q + 3'h1;
    t1_ovf <= (div_q == 3'h7) && !ovf_hold;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    @(negedge mclk);
    sfr_bit_addr = a;
    sfr_bit_val = v;
    sfr_bit_wr = 1'b1;
    @(negedge mclk);
    sfr_bit_wr = 1'b0;
  endtask
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    check(what, sfr_rdata, exp);
  endtask
  task automatic rx_frame(input logic [7:0] d, input logic nine, input logic ninth, input logic stop);
    nbu_remote_node_inst.send(d, nine, ninth, stop);
  endtask
  task automatic wait_tx(input int target, input int limit);
    for (int i = 0; i < limit && nbu_remote_node_inst.got_cnt < target; i++)
      @(posedge mclk);
    check("frames heard in time", 11'(nbu_remote_node_inst.got_cnt >= target), 11'h001);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    expect_reg("control reset", CTL, 8'h40);
    wr(CTL, 8'h00);
    expect_reg("unused bit", CTL, 8'h40);
    wr(CTL, 8'hbc);
    expect_reg("control fields", CTL, 8'hfc);
    expect_reg("unmapped", 8'h9a, 8'h00);
    wr(CTL, 8'h02);
    @(negedge mclk);
    check("irq on flag", irq, 1'b1);
    irq_enable = 1'b0;
    repeat (2) @(negedge mclk);
    check("irq masked", irq, 1'b0);
    irq_enable = 1'b1;
    bw(8'h99, 1'b0);
    repeat (2) @(negedge mclk);
    check("irq cleared", irq, 1'b0);
  endtask
  task automatic t_tx;
    int base;
    base = nbu_remote_node_inst.got_cnt;
    wr(CTL, 8'h88);
    wr(DAT, 8'ha5);
    wr(DAT, 8'h5a);
    wait_tx(base + 1, 400);
    check("frame one", nbu_remote_node_inst.got_q, {2'b11, 8'ha5, 1'b0});
    expect_reg("tx done", CTL, 8'hca);
    wait_tx(base + 2, 400);
    check("frame two", nbu_remote_node_inst.got_q, {2'b11, 8'h5a, 1'b0});
  endtask
  task automatic t_rx;
    wr(CTL, 8'h90);
    rx_frame(8'h3c, 1'b1, 1'b1, 1'b0);
    expect_reg("ninth kept, stop ignored", CTL, 8'hd5);
    check("irq on receive", irq, 1'b1);
    expect_reg("rx byte", DAT, 8'h3c);
    rx_frame(8'h11, 1'b1, 1'b0, 1'b1);
    expect_reg("flags kept", CTL, 8'hd5);
    expect_reg("byte kept", DAT, 8'h3c);
  endtask
  task automatic t_filter;
    wr(CTL, 8'hb0);
    rx_frame(8'h55, 1'b1, 1'b0, 1'b1);
    expect_reg("data filtered", CTL, 8'hf0);
    rx_frame(8'h66, 1'b1, 1'b1, 1'b1);
    expect_reg("address taken", CTL, 8'hf5);
    bw(8'h9d, 1'b0); // filter off after address match
    bw(8'h98, 1'b0);
    rx_frame(8'h77, 1'b1, 1'b0, 1'b1);
    expect_reg("data after match", CTL, 8'hd1);
    expect_reg("data byte", DAT, 8'h77);
  endtask
  task automatic t_modes;
    int base;
    wr(CTL, 8'h80);
    rx_frame(8'h42, 1'b1, 1'b1, 1'b1);
    expect_reg("receiver off", CTL, 8'hc0);
    expect_reg("byte untouched", DAT, 8'h77);
    wr(CTL, 8'h30);
    rx_frame(8'h24, 1'b0, 1'b0, 1'b0);
    expect_reg("bad stop filtered", CTL, 8'h70);
    rx_frame(8'h24, 1'b0, 1'b0, 1'b1);
    expect_reg("eight bit frame", CTL, 8'h75);
    expect_reg("eight bit byte", DAT, 8'h24);
    // eight-bit transmit: no ninth bit between data and stop
    base = nbu_remote_node_inst.got_cnt;
    wr(CTL, 8'h00);
    wr(DAT, 8'hc3);
    wait_tx(base + 1, 400);
    check("eight bit tx", nbu_remote_node_inst.got_q, {2'b11, 8'hc3, 1'b0});
    expect_reg("eight bit tx done", CTL, 8'h42);
  endtask
  task automatic t_fill;
    int n;
    int base;
    base = nbu_remote_node_inst.got_cnt;
    n = 0;
    // bit rate stalled so the fill and the dropped write do not race a pop
    ovf_hold <= 1'b1;
    wr(CTL, 8'h88);
    while (tx_ready === 1'b1 && n < 40)
    begin
      wr(DAT, 8'(n));
      n++;
    end
    check("queue refuses", tx_ready, 1'b0);
    wr(DAT, 8'hee);
    ovf_hold <= 1'b0;
    wait_tx(base + n, 9000);
    repeat (300) @(posedge mclk);
    check("frames sent", 11'(nbu_remote_node_inst.got_cnt - base), 11'(n));
    check("last frame", nbu_remote_node_inst.got_q, {2'b11, 8'(n - 1), 1'b0});
    check("queue drained", tx_ready, 1'b1);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    srst = 1'b1;
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val} = 4'h0;
    {sfr_addr, sfr_wdata, sfr_bit_addr} = 24'h000000;
    t1_tick = 1'b1;
    t1_reload = 8'hf8;
    irq_enable = 1'b1;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_filter;
    t_modes;
    t_fill;
    tally_and_finish;
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    tally_and_finish;
  end
endmodule // tb_nine_bit_uart_multiproc

bind nbu_top nbu_checker nbu_checker_inst (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr), .sfr_rdata(sfr_rdata), .t1_ovf(t1_ovf),
  .irq_enable(irq_enable), .irq(irq), .tx_ready(tx_ready), .txd(txd));

`default_nettype wire
